// ### host_ctrl_model.sv
// host-side model: drives the decoder's word read port and status word port
// assumes the caller steps it from the falling clock edge, one request a cycle
`timescale 1ns/10ps
module host_ctrl_model
    import status_control_config_map_pkg::*;
(
    // clock
    input  wire logic   clk_i,
    // requests toward the decoder
    output word_req_t   rd_req_o,
    output logic        busy_word_valid_o,
    output logic [15:0] busy_word_o,
    output logic        perr_word_valid_o,
    output logic [15:0] perr_word_o
);
    // quiet lines at time zero
    initial
    begin
        rd_req_o          = '0;
        busy_word_valid_o = 1'b0;
        busy_word_o       = 16'h0000;
        perr_word_valid_o = 1'b0;
        perr_word_o       = 16'h0000;
    end

    // physical address of a status register: block base plus the placed local address
    function automatic logic [31:0] phys(input logic [31:0] base, input logic [7:0] loc,
                                         input logic byte1);
        phys = base + (byte1 ? {16'h0000, loc, 8'h00} : {24'h000000, loc});
    endfunction

    // change only the chosen bits of a register image, keep the rest as read back
    function automatic logic [15:0] merge(input logic [15:0] cur, input logic [15:0] mask,
                                          input logic [15:0] val);
        merge = (cur & ~mask) | (val & mask);
    endfunction

    // one cycle of requests, held until the next falling edge; released word lines
    // flip so a stale value can never pass for a fresh one
    task automatic drive(input logic rv, input logic [1:0] idx, input logic bv,
                         input logic [15:0] bw, input logic pv, input logic [15:0] pw);
        rd_req_o.valid    <= rv;
        rd_req_o.idx      <= idx;
        busy_word_valid_o <= bv;
        busy_word_o       <= bv ? bw : ~busy_word_o;
        perr_word_valid_o <= pv;
        perr_word_o       <= pv ? pw : ~perr_word_o;
        @(negedge clk_i);
    endtask
endmodule

// ### status_control_config_map_cfg.svh
// constants for the register map decoder: word indices, field positions, codes
// assumes inclusion by bare name from every file that decodes the table
`ifndef STATUS_CONTROL_CONFIG_MAP_MAP_CFG_SVH
`define STATUS_CONTROL_CONFIG_MAP_MAP_CFG_SVH

// parameter word indices and table size
`define STATUS_CONTROL_CONFIG_MAP_IDX_VOL       2'h0
`define STATUS_CONTROL_CONFIG_MAP_IDX_NVOL      2'h1
`define STATUS_CONTROL_CONFIG_MAP_IDX_CMD       2'h2
`define STATUS_CONTROL_CONFIG_MAP_IDX_PERR      2'h3
`define STATUS_CONTROL_CONFIG_MAP_NUM_WORDS     4
`define STATUS_CONTROL_CONFIG_MAP_LAST_IDX      2'h3

// third word: generic register command info
`define STATUS_CONTROL_CONFIG_MAP_RD_SUP        31
`define STATUS_CONTROL_CONFIG_MAP_WR_SUP        30
`define STATUS_CONTROL_CONFIG_MAP_CALEN_HI      29
`define STATUS_CONTROL_CONFIG_MAP_CALEN_LO      28
`define STATUS_CONTROL_CONFIG_MAP_VDUM_HI       27
`define STATUS_CONTROL_CONFIG_MAP_VDUM_LO       23
`define STATUS_CONTROL_CONFIG_MAP_NDUM_HI       22
`define STATUS_CONTROL_CONFIG_MAP_NDUM_LO       18
`define STATUS_CONTROL_CONFIG_MAP_BUSY_SUP      17
`define STATUS_CONTROL_CONFIG_MAP_BUSY_POL      16
`define STATUS_CONTROL_CONFIG_MAP_BUSY_LOC      15
`define STATUS_CONTROL_CONFIG_MAP_BUSY_POS_HI   14
`define STATUS_CONTROL_CONFIG_MAP_BUSY_POS_LO   11
`define STATUS_CONTROL_CONFIG_MAP_BUSY_ADR_HI   10
`define STATUS_CONTROL_CONFIG_MAP_BUSY_ADR_LO   3
`define STATUS_CONTROL_CONFIG_MAP_CMD_RSV_HI    2

// fourth word: program error locator
`define STATUS_CONTROL_CONFIG_MAP_PE_SUP        31
`define STATUS_CONTROL_CONFIG_MAP_PE_POL        30
`define STATUS_CONTROL_CONFIG_MAP_PE_LOC        29
`define STATUS_CONTROL_CONFIG_MAP_PE_SHR        28
`define STATUS_CONTROL_CONFIG_MAP_PE_POS_HI     27
`define STATUS_CONTROL_CONFIG_MAP_PE_POS_LO     24
`define STATUS_CONTROL_CONFIG_MAP_PE_ADR_HI     23
`define STATUS_CONTROL_CONFIG_MAP_PE_ADR_LO     16
`define STATUS_CONTROL_CONFIG_MAP_PERR_RSV_HI   15

// codes
`define STATUS_CONTROL_CONFIG_MAP_CALEN_6B      2'h0
`define STATUS_CONTROL_CONFIG_MAP_ZERO32        32'h0000_0000

`endif

// ### status_control_config_map_pkg.sv
// types shared by the register map decoder, the host model and the bench
// assumes status_control_config_map_cfg.svh is compiled alongside
package status_control_config_map_pkg;

    // loader state, one-hot
    typedef enum logic [1:0]
    {
        ST_LOAD  = 2'b01,
        ST_READY = 2'b10
    } load_state_t;

    // decoded fields of the third and fourth words
    typedef struct packed
    {
        logic       rd_sup;
        logic       wr_sup;
        logic [1:0] ca_len;
        logic       ca_usable;
        logic [4:0] vol_dummy;
        logic [4:0] nvol_dummy;
        logic       busy_sup;
        logic       busy_pol;
        logic       busy_byte1;
        logic [3:0] busy_pos;
        logic [7:0] busy_addr;
        logic       pe_sup;
        logic       pe_pol;
        logic       pe_byte1;
        logic       pe_shared;
        logic [3:0] pe_pos;
        logic [7:0] pe_addr;
    } status_control_config_map_fields_t;

    // a word read request
    typedef struct packed
    {
        logic       valid;
        logic [1:0] idx;
    } word_req_t;

endpackage

// ### status_control_config_map_word_mem.sv
// small table memory: one write port, one read port with registered data
// assumes a single clock and a synchronous active-low reset
`timescale 1ns/10ps
module status_control_config_map_word_mem
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4,
    parameter int AW    = 2
)
(
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    // write side
    input  wire logic             wr_en_i,
    input  wire logic [AW-1:0]    wr_addr_i,
    input  wire logic [WIDTH-1:0] wr_data_i,
    // read side
    input  wire logic             rd_en_i,
    input  wire logic [AW-1:0]    rd_addr_i,
    output logic      [WIDTH-1:0] rd_data_o
);

    logic [WIDTH-1:0] mem_reg [DEPTH];

    // storage has no reset; the loader fills every word before reads open
    always_ff @(posedge clk_i)
    begin
        if (wr_en_i)
        begin
            mem_reg[wr_addr_i] <= wr_data_i;
        end
    end

    // read data registered so the output never glitches
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            rd_data_o <= '0;
        end
        else if (rd_en_i)
        begin
            rd_data_o <= mem_reg[rd_addr_i];
        end
    end

endmodule

// ### status_reg_map_decoder.sv
// register map decoder: serves the four parameter words and decodes them
// assumes one clock, synchronous reset, requests from logic on the same clock
`timescale 1ns/10ps
`include "status_control_config_map_cfg.svh"
module status_reg_map_decoder
    import status_control_config_map_pkg::*;
#(
    parameter logic [31:0] VOL_BASE   = 32'h0000_0000,
    parameter logic [31:0] NVOL_BASE  = 32'h0000_1000,
    parameter logic        RD_SUP     = 1'b1,
    parameter logic        WR_SUP     = 1'b1,
    parameter logic [4:0]  VOL_DUMMY  = 5'h04,
    parameter logic [4:0]  NVOL_DUMMY = 5'h08,
    parameter logic        BUSY_SUP   = 1'b1,
    parameter logic        BUSY_POL   = 1'b0,
    parameter logic        BUSY_BYTE1 = 1'b0,
    parameter logic [3:0]  BUSY_POS   = 4'h0,
    parameter logic [7:0]  BUSY_ADDR  = 8'h00,
    parameter logic        PE_SUP     = 1'b1,
    parameter logic        PE_POL     = 1'b0,
    parameter logic        PE_BYTE1   = 1'b0,
    parameter logic        PE_SHARED  = 1'b0,
    parameter logic [3:0]  PE_POS     = 4'h5,
    parameter logic [7:0]  PE_ADDR    = 8'h00
)
(
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    // parameter word reads
    input  wire word_req_t    rd_req_i,
    output logic              rd_ready_o,
    output logic              rd_valid_o,
    output logic [31:0]       rd_data_o,
    // decoded table
    output status_control_config_map_fields_t      fields_o,
    output logic [31:0]       busy_phys_addr_o,
    output logic [31:0]       perr_phys_addr_o,
    // status word interpretation
    input  wire logic         busy_word_valid_i,
    input  wire logic [15:0]  busy_word_i,
    input  wire logic         perr_word_valid_i,
    input  wire logic [15:0]  perr_word_i,
    output logic              write_busy_flag_o,
    output logic              prog_fail_o,
    output logic              stat_done_o
);

    load_state_t  state_reg;
    logic [1:0]   load_idx_reg;
    logic         mem_wr;
    logic [31:0]  mem_wdata;
    logic         rd_take;

    // compose one parameter word from the configuration
    function automatic logic [31:0] build_word(input logic [1:0] idx);
        logic [31:0] w;
        w = `STATUS_CONTROL_CONFIG_MAP_ZERO32;
        unique case (idx)
            `STATUS_CONTROL_CONFIG_MAP_IDX_VOL:  w = VOL_BASE;
            `STATUS_CONTROL_CONFIG_MAP_IDX_NVOL: w = NVOL_BASE;
            `STATUS_CONTROL_CONFIG_MAP_IDX_CMD:
            begin
                w[`STATUS_CONTROL_CONFIG_MAP_RD_SUP]                        = RD_SUP;
                w[`STATUS_CONTROL_CONFIG_MAP_WR_SUP]                        = WR_SUP;
                w[`STATUS_CONTROL_CONFIG_MAP_CALEN_HI:`STATUS_CONTROL_CONFIG_MAP_CALEN_LO]       = `STATUS_CONTROL_CONFIG_MAP_CALEN_6B;
                w[`STATUS_CONTROL_CONFIG_MAP_VDUM_HI:`STATUS_CONTROL_CONFIG_MAP_VDUM_LO]         = VOL_DUMMY;
                w[`STATUS_CONTROL_CONFIG_MAP_NDUM_HI:`STATUS_CONTROL_CONFIG_MAP_NDUM_LO]         = NVOL_DUMMY;
                w[`STATUS_CONTROL_CONFIG_MAP_BUSY_SUP]                      = BUSY_SUP;
                w[`STATUS_CONTROL_CONFIG_MAP_BUSY_POL]                      = BUSY_POL;
                w[`STATUS_CONTROL_CONFIG_MAP_BUSY_LOC]                      = BUSY_BYTE1;
                w[`STATUS_CONTROL_CONFIG_MAP_BUSY_POS_HI:`STATUS_CONTROL_CONFIG_MAP_BUSY_POS_LO] = BUSY_POS;
                w[`STATUS_CONTROL_CONFIG_MAP_BUSY_ADR_HI:`STATUS_CONTROL_CONFIG_MAP_BUSY_ADR_LO] = BUSY_ADDR;
            end
            `STATUS_CONTROL_CONFIG_MAP_IDX_PERR:
            begin
                w[`STATUS_CONTROL_CONFIG_MAP_PE_SUP]                        = PE_SUP;
                w[`STATUS_CONTROL_CONFIG_MAP_PE_POL]                        = PE_POL;
                w[`STATUS_CONTROL_CONFIG_MAP_PE_LOC]                        = PE_BYTE1;
                w[`STATUS_CONTROL_CONFIG_MAP_PE_SHR]                        = PE_SHARED;
                w[`STATUS_CONTROL_CONFIG_MAP_PE_POS_HI:`STATUS_CONTROL_CONFIG_MAP_PE_POS_LO]     = PE_POS;
                w[`STATUS_CONTROL_CONFIG_MAP_PE_ADR_HI:`STATUS_CONTROL_CONFIG_MAP_PE_ADR_LO]     = PE_ADDR;
            end
        endcase
        return w;   // unset bits, the reserved fields among them, stay zero
    endfunction

    // split the third and fourth words into named fields
    function automatic status_control_config_map_fields_t decode(input logic [31:0] c, input logic [31:0] p);
        status_control_config_map_fields_t f;
        f.rd_sup     = c[`STATUS_CONTROL_CONFIG_MAP_RD_SUP];
        f.wr_sup     = c[`STATUS_CONTROL_CONFIG_MAP_WR_SUP];
        f.ca_len     = c[`STATUS_CONTROL_CONFIG_MAP_CALEN_HI:`STATUS_CONTROL_CONFIG_MAP_CALEN_LO];
        f.ca_usable  = (c[`STATUS_CONTROL_CONFIG_MAP_CALEN_HI:`STATUS_CONTROL_CONFIG_MAP_CALEN_LO] == `STATUS_CONTROL_CONFIG_MAP_CALEN_6B);
        f.vol_dummy  = c[`STATUS_CONTROL_CONFIG_MAP_VDUM_HI:`STATUS_CONTROL_CONFIG_MAP_VDUM_LO];
        f.nvol_dummy = c[`STATUS_CONTROL_CONFIG_MAP_NDUM_HI:`STATUS_CONTROL_CONFIG_MAP_NDUM_LO];
        f.busy_sup   = c[`STATUS_CONTROL_CONFIG_MAP_BUSY_SUP];
        f.busy_pol   = c[`STATUS_CONTROL_CONFIG_MAP_BUSY_POL];
        f.busy_byte1 = c[`STATUS_CONTROL_CONFIG_MAP_BUSY_LOC];
        f.busy_pos   = c[`STATUS_CONTROL_CONFIG_MAP_BUSY_POS_HI:`STATUS_CONTROL_CONFIG_MAP_BUSY_POS_LO];
        f.busy_addr  = c[`STATUS_CONTROL_CONFIG_MAP_BUSY_ADR_HI:`STATUS_CONTROL_CONFIG_MAP_BUSY_ADR_LO];
        f.pe_sup     = p[`STATUS_CONTROL_CONFIG_MAP_PE_SUP];
        f.pe_pol     = p[`STATUS_CONTROL_CONFIG_MAP_PE_POL];
        f.pe_byte1   = p[`STATUS_CONTROL_CONFIG_MAP_PE_LOC];
        f.pe_shared  = p[`STATUS_CONTROL_CONFIG_MAP_PE_SHR];
        f.pe_pos     = p[`STATUS_CONTROL_CONFIG_MAP_PE_POS_HI:`STATUS_CONTROL_CONFIG_MAP_PE_POS_LO];
        f.pe_addr    = p[`STATUS_CONTROL_CONFIG_MAP_PE_ADR_HI:`STATUS_CONTROL_CONFIG_MAP_PE_ADR_LO];
        return f;
    endfunction

    // base plus local address, local placed in the last byte or in byte 1
    function automatic logic [31:0] phys_addr(input logic [31:0] base,
                                              input logic [7:0]  loc,
                                              input logic        byte1);
        return byte1 ? base + {16'h0000, loc, 8'h00} : base + {24'h00_0000, loc};
    endfunction

    // pick a flag from a status word; an absent flag always reads inactive
    function automatic logic flag_active(input logic [15:0] word,
                                         input logic [3:0]  pos,
                                         input logic        pol,
                                         input logic        sup);
        return sup & (word[pos] ^ pol);
    endfunction

    // loader: writes the four words after reset, then opens reads
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            state_reg    <= ST_LOAD;
            load_idx_reg <= `STATUS_CONTROL_CONFIG_MAP_IDX_VOL;
        end
        else
        begin
            unique case (state_reg)
                ST_LOAD:
                begin
                    load_idx_reg <= load_idx_reg + 2'h1;
                    if (load_idx_reg == `STATUS_CONTROL_CONFIG_MAP_LAST_IDX)
                    begin
                        state_reg <= ST_READY;
                    end
                end
                ST_READY: state_reg <= ST_READY;
                default:  state_reg <= ST_LOAD;   // recover from a corrupted code
            endcase
        end
    end

    assign mem_wr     = (state_reg == ST_LOAD);
    assign mem_wdata  = build_word(load_idx_reg);
    assign rd_ready_o = (state_reg == ST_READY);
    assign rd_take    = rd_req_i.valid & rd_ready_o;

    status_control_config_map_word_mem
    #(
        .WIDTH (32),
        .DEPTH (`STATUS_CONTROL_CONFIG_MAP_NUM_WORDS),
        .AW    (2)
    )
    u_table
    (
        .clk_i     (clk_i),
        .rst_n_i   (rst_n_i),
        .wr_en_i   (mem_wr),
        .wr_addr_i (load_idx_reg),
        .wr_data_i (mem_wdata),
        .rd_en_i   (rd_take),
        .rd_addr_i (rd_req_i.idx),
        .rd_data_o (rd_data_o)
    );

    // answer strobe one cycle after a taken read
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            rd_valid_o <= 1'b0;
        end
        else
        begin
            rd_valid_o <= rd_take;
        end
    end

    // decoded fields and physical addresses, latched as the last word loads
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            fields_o         <= '0;
            busy_phys_addr_o <= `STATUS_CONTROL_CONFIG_MAP_ZERO32;
            perr_phys_addr_o <= `STATUS_CONTROL_CONFIG_MAP_ZERO32;
        end
        else if (mem_wr && load_idx_reg == `STATUS_CONTROL_CONFIG_MAP_LAST_IDX)
        begin
            fields_o         <= decode(build_word(`STATUS_CONTROL_CONFIG_MAP_IDX_CMD), build_word(`STATUS_CONTROL_CONFIG_MAP_IDX_PERR));
            // status flags live in the volatile block
            busy_phys_addr_o <= phys_addr(VOL_BASE, BUSY_ADDR, BUSY_BYTE1);
            perr_phys_addr_o <= phys_addr(VOL_BASE, PE_ADDR, PE_BYTE1);
        end
    end

    // interpret status words read back from the memory
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            write_busy_flag_o <= 1'b0;
            prog_fail_o       <= 1'b0;
            stat_done_o       <= 1'b0;
        end
        else
        begin
            stat_done_o <= rd_ready_o & (busy_word_valid_i | perr_word_valid_i);
            if (rd_ready_o && busy_word_valid_i)
            begin
                write_busy_flag_o <= flag_active(busy_word_i, fields_o.busy_pos,
                                                 fields_o.busy_pol, fields_o.busy_sup);
            end
            if (rd_ready_o && perr_word_valid_i)
            begin
                prog_fail_o <= flag_active(perr_word_i, fields_o.pe_pos,
                                           fields_o.pe_pol, fields_o.pe_sup);
            end
        end
    end

    // checks
    property p_vol_word;
        @(posedge clk_i) disable iff (!rst_n_i)
        rd_take && rd_req_i.idx == `STATUS_CONTROL_CONFIG_MAP_IDX_VOL |=> rd_valid_o && rd_data_o == VOL_BASE;
    endproperty
    a_vol_word: assert property (p_vol_word) else $error("volatile base word wrong");

    property p_nvol_word;
        @(posedge clk_i) disable iff (!rst_n_i)
        rd_take && rd_req_i.idx == `STATUS_CONTROL_CONFIG_MAP_IDX_NVOL |=> rd_data_o == NVOL_BASE;
    endproperty
    a_nvol_word: assert property (p_nvol_word) else $error("non-volatile base wrong");

    property p_cmd_flags;
        @(posedge clk_i) disable iff (!rst_n_i)
        rd_take && rd_req_i.idx == `STATUS_CONTROL_CONFIG_MAP_IDX_CMD |=>
            rd_data_o[`STATUS_CONTROL_CONFIG_MAP_RD_SUP] == RD_SUP && rd_data_o[`STATUS_CONTROL_CONFIG_MAP_WR_SUP] == WR_SUP
            && rd_data_o[`STATUS_CONTROL_CONFIG_MAP_BUSY_SUP] == BUSY_SUP;
    endproperty
    a_cmd_flags: assert property (p_cmd_flags) else $error("command support bits wrong");

    property p_calen;
        @(posedge clk_i) disable iff (!rst_n_i)
        rd_ready_o |-> fields_o.ca_len == `STATUS_CONTROL_CONFIG_MAP_CALEN_6B && fields_o.ca_usable;
    endproperty
    a_calen: assert property (p_calen) else $error("command-address length not six bytes");

    property p_dummy;
        @(posedge clk_i) disable iff (!rst_n_i)
        rd_take && rd_req_i.idx == `STATUS_CONTROL_CONFIG_MAP_IDX_CMD |=>
            rd_data_o[`STATUS_CONTROL_CONFIG_MAP_VDUM_HI:`STATUS_CONTROL_CONFIG_MAP_VDUM_LO] == fields_o.vol_dummy
            && fields_o.nvol_dummy == NVOL_DUMMY && fields_o.vol_dummy == VOL_DUMMY;
    endproperty
    a_dummy: assert property (p_dummy) else $error("dummy cycle counts wrong");

    property p_busy_decode;
        @(posedge clk_i) disable iff (!rst_n_i)
        rd_ready_o && busy_word_valid_i |=> stat_done_o && write_busy_flag_o ==
            (BUSY_SUP && ($past(busy_word_i[BUSY_POS]) != BUSY_POL));
    endproperty
    a_busy_decode: assert property (p_busy_decode) else $error("busy flag decode wrong");

    property p_busy_addr;
        @(posedge clk_i) disable iff (!rst_n_i)
        rd_ready_o |-> busy_phys_addr_o == (BUSY_BYTE1 ? VOL_BASE + {16'h0000, BUSY_ADDR, 8'h00}
                                                       : VOL_BASE + {24'h00_0000, BUSY_ADDR})
                       && fields_o.busy_addr == BUSY_ADDR && fields_o.busy_pos == BUSY_POS;
    endproperty
    a_busy_addr: assert property (p_busy_addr) else $error("busy register address wrong");

    property p_reserved;
        @(posedge clk_i) disable iff (!rst_n_i)
        rd_take && (rd_req_i.idx == `STATUS_CONTROL_CONFIG_MAP_IDX_CMD || rd_req_i.idx == `STATUS_CONTROL_CONFIG_MAP_IDX_PERR) |=>
            ($past(rd_req_i.idx) == `STATUS_CONTROL_CONFIG_MAP_IDX_CMD) ? rd_data_o[`STATUS_CONTROL_CONFIG_MAP_CMD_RSV_HI:0] == 3'h0
                                            : rd_data_o[`STATUS_CONTROL_CONFIG_MAP_PERR_RSV_HI:0] == 16'h0000;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

    property p_perr_word;
        @(posedge clk_i) disable iff (!rst_n_i)
        rd_take && rd_req_i.idx == `STATUS_CONTROL_CONFIG_MAP_IDX_PERR |=>
            rd_data_o[`STATUS_CONTROL_CONFIG_MAP_PE_SUP] == PE_SUP && rd_data_o[`STATUS_CONTROL_CONFIG_MAP_PE_SHR] == PE_SHARED
            && rd_data_o[`STATUS_CONTROL_CONFIG_MAP_PE_ADR_HI:`STATUS_CONTROL_CONFIG_MAP_PE_ADR_LO] == PE_ADDR
            && rd_data_o[`STATUS_CONTROL_CONFIG_MAP_PE_POS_HI:`STATUS_CONTROL_CONFIG_MAP_PE_POS_LO] == PE_POS;
    endproperty
    a_perr_word: assert property (p_perr_word) else $error("program error word wrong");

    property p_perr_decode;
        @(posedge clk_i) disable iff (!rst_n_i)
        rd_ready_o && perr_word_valid_i |=> prog_fail_o ==
            (PE_SUP && ($past(perr_word_i[PE_POS]) != PE_POL));
    endproperty
    a_perr_decode: assert property (p_perr_decode) else $error("program error decode wrong");

endmodule

// ### test_status_reg_map_decoder.sv
// self-checking bench: a default decoder and an inverted-polarity one share one host model
// assumes status_control_config_map_pkg and host_ctrl_model are compiled first
`timescale 1ns/10ps
module test_status_reg_map_decoder
    import status_control_config_map_pkg::*;
;
    logic         clk_i;
    logic         rst_n_i;
    word_req_t    rd_req;
    logic         bwv, pwv, rdy_a, rdy_b, vld_a, vld_b, busy_a, busy_b;
    logic         fail_a, fail_b, done_a, done_b, sh_ba, sh_bb, sh_fa, sh_fb;
    logic [15:0]  bw, pw;
    logic [31:0]  data_a, data_b, bpa_a, bpa_b, ppa_a, ppa_b, r, r2;
    logic [31:0]  wa [4];
    logic [31:0]  wb [4];
    logic [63:0]  e;
    logic [3:0]   s;
    logic [63:0]  rq [$];
    logic [3:0]   sq [$];
    status_control_config_map_fields_t fields_a, fields_b;
    integer       mismatches, checked, seed, i, k;

    host_ctrl_model u_host_ctrl_model (.clk_i(clk_i), .rd_req_o(rd_req),
        .busy_word_valid_o(bwv), .busy_word_o(bw), .perr_word_valid_o(pwv), .perr_word_o(pw));

    // default table: positive polarities, last-byte placement
    status_reg_map_decoder u_status_reg_map_decoder (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .rd_req_i(rd_req), .rd_ready_o(rdy_a),
        .rd_valid_o(vld_a), .rd_data_o(data_a), .fields_o(fields_a),
        .busy_phys_addr_o(bpa_a), .perr_phys_addr_o(ppa_a), .busy_word_valid_i(bwv),
        .busy_word_i(bw), .perr_word_valid_i(pwv), .perr_word_i(pw),
        .write_busy_flag_o(busy_a), .prog_fail_o(fail_a), .stat_done_o(done_a));

    // inverted busy at bit 15, busy address in byte 1, inverted program error
    status_reg_map_decoder #(.BUSY_POL(1'b1), .BUSY_BYTE1(1'b1), .BUSY_POS(4'hf),
        .BUSY_ADDR(8'ha5), .PE_POL(1'b1)) u_status_reg_map_decoder_alt (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .rd_req_i(rd_req), .rd_ready_o(rdy_b),
        .rd_valid_o(vld_b), .rd_data_o(data_b), .fields_o(fields_b),
        .busy_phys_addr_o(bpa_b), .perr_phys_addr_o(ppa_b), .busy_word_valid_i(bwv),
        .busy_word_i(bw), .perr_word_valid_i(pwv), .perr_word_i(pw),
        .write_busy_flag_o(busy_b), .prog_fail_o(fail_b), .stat_done_o(done_b));

    // 10 MHz clock
    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // expectations are noted here, before the request leaves the host model
    task automatic step(input logic rv, input logic [1:0] idx, input logic bv,
                        input logic [15:0] bwd, input logic pv, input logic [15:0] pwd);
        if (rv) rq.push_back({wa[idx], wb[idx]});
        if (bv) sh_ba = bwd[0];
        if (bv) sh_bb = ~bwd[15];
        if (pv) sh_fa = pwd[5];
        if (pv) sh_fb = ~pwd[5];
        if (bv || pv) sq.push_back({sh_ba, sh_fa, sh_bb, sh_fb});
        u_host_ctrl_model.drive(rv, idx, bv, bwd, pv, pwd);
    endtask

    task automatic idle_check();
        chk("quiet_ctl", 64'h0, {rdy_a, vld_a, done_a, busy_a, fail_a});
        chk("quiet_fields", 64'h0, fields_a);
        chk("quiet_addr", 64'h0, {bpa_a, ppa_a});
        chk("quiet_data", 64'h0, data_a);
    endtask

    // release reset while both ports already ask; nothing may answer during the load
    task automatic load();
        rst_n_i = 1'b1;
        sh_ba = 1'b0;
        sh_bb = 1'b0;
        sh_fa = 1'b0;
        sh_fb = 1'b0;
        for (k = 1; k <= 4; k++)
        begin
            u_host_ctrl_model.drive(1'b1, 2'h2, 1'b1, 16'h0000, 1'b1, 16'h0008);
            if (k == 1) idle_check();
            chk("ready", k == 4, rdy_a & rdy_b);
        end
        chk("fields_a", {4'b1100, 1'b1, 5'h04, 5'h08, 3'b100, 4'h0, 8'h00,
            4'b1000, 4'h5, 8'h00}, fields_a);
        chk("fields_b", {4'b1100, 1'b1, 5'h04, 5'h08, 3'b111, 4'hf, 8'ha5,
            4'b1100, 4'h5, 8'h00}, fields_b);
        chk("busy_phys_a", u_host_ctrl_model.phys(32'h0000_0000, 8'h00, 1'b0), bpa_a);
        chk("perr_phys_a", u_host_ctrl_model.phys(32'h0000_0000, 8'h00, 1'b0), ppa_a);
        chk("busy_phys_b", u_host_ctrl_model.phys(32'h0000_0000, 8'ha5, 1'b1), bpa_b);
        chk("perr_phys_b", u_host_ctrl_model.phys(32'h0000_0000, 8'h00, 1'b0), ppa_b);
    endtask

    // result watcher: every answer takes the oldest note
    always @(negedge clk_i)
    begin
        if (rst_n_i && (vld_a || vld_b))
        begin
            chk("read_noted", 64'h1, rq.size() != 0);
            chk("read_pair", 64'h3, {vld_a, vld_b});
            if (rq.size() != 0)
            begin
                e = rq.pop_front();
                chk("word_a", e[63:32], data_a);
                chk("word_b", e[31:0], data_b);
            end
        end
        if (rst_n_i && (done_a || done_b))
        begin
            chk("status_noted", 64'h1, sq.size() != 0);
            if (sq.size() != 0)
            begin
                s = sq.pop_front();
                chk("status_flags", s, {busy_a, fail_a, busy_b, fail_b});
            end
        end
    end

    // hang guard, well beyond the hundred or so cycles the sequence needs
    initial
    begin
        #(100 * 5000);
        mismatches++;
        tally_and_finish();
    end

    initial
    begin
        seed = 32'haa9ca939;
        mismatches = 0;
        checked = 0;
        rst_n_i = 1'b0;
        repeat (4) @(negedge clk_i);
        idle_check();
        repeat (4) @(negedge clk_i);
        load();
        // every word back to back, then in reverse
        for (i = 0; i < 8; i++) step(1'b1, (i < 4) ? i[1:0] : ~i[1:0], 1'b0, 16'h0000, 1'b0,
            16'h0000);
        // random mix of reads, status words, both at once and idle cycles
        for (i = 0; i < 60; i++)
        begin
            r = $random(seed);
            r2 = $random(seed);
            step(r[0], r[2:1], r[3], r2[31:16], r[4], r2[15:0]);
        end
        // after a program: poll busy until idle, then read the error flag
        step(1'b0, 2'h0, 1'b1, u_host_ctrl_model.merge(16'h5a5a, 16'h0001, 16'h0001), 1'b0,
            16'h0000);
        k = 0;
        while (busy_a !== 1'b0 && k < 8)
        begin
            step(1'b0, 2'h0, 1'b1, u_host_ctrl_model.merge(16'h5a5a, 16'h0001,
                {15'h0000, k < 2}), 1'b0, 16'h0000);
            k++;
        end
        chk("poll_idle", 64'h0, busy_a);
        chk("poll_count", 64'h3, k);
        step(1'b0, 2'h0, 1'b0, 16'h0000, 1'b1, 16'h0008);
        step(1'b0, 2'h0, 1'b0, 16'h0000, 1'b0, 16'h0000);
        // second reset in mid-run, then the table must come back whole
        rst_n_i = 1'b0;
        step(1'b0, 2'h0, 1'b0, 16'h0000, 1'b0, 16'h0000);
        step(1'b0, 2'h0, 1'b0, 16'h0000, 1'b0, 16'h0000);
        idle_check();
        load();
        for (i = 0; i < 4; i++) step(1'b1, i[1:0], 1'b1, 16'h7fff, 1'b1, 16'h8000);
        step(1'b0, 2'h0, 1'b0, 16'h0000, 1'b0, 16'h0000);
        step(1'b0, 2'h0, 1'b0, 16'h0000, 1'b0, 16'h0000);
        chk("notes_left", 64'h0, rq.size() + sq.size());
        tally_and_finish();
    end

    // expected table words, built field by field
    initial
    begin
        wa[0] = 32'h0000_0000;
        wa[1] = 32'h0000_1000;
        wa[2] = {4'b1100, 5'h04, 5'h08, 3'b100, 4'h0, 8'h00, 3'h0};
        wa[3] = {4'b1000, 4'h5, 8'h00, 16'h0000};
        wb[0] = 32'h0000_0000;
        wb[1] = 32'h0000_1000;
        wb[2] = {4'b1100, 5'h04, 5'h08, 3'b111, 4'hf, 8'ha5, 3'h0};
        wb[3] = {4'b1100, 4'h5, 8'h00, 16'h0000};
    end
endmodule
